// ==== hdl/irq_resp_pkg.sv ====
// package for the interrupt response unit: register map, reset values,
// fixed vector codes, response kinds and the carrier structs.
// assumes a 32-bit apb register bus and a processor core around it.
package irq_resp_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] VLOW_INDEX = 8'h33;  // vector_low_reg index
  localparam logic [7:0] TRAP_CTRL_INDEX = 8'h34;  // trap_control_reg index
  localparam logic [11:0] VLOW_ADDR = {2'h0, VLOW_INDEX, 2'h0};
  localparam logic [11:0] TRAP_CTRL_ADDR = {2'h0, TRAP_CTRL_INDEX, 2'h0};
  localparam logic [11:0] VBASE_ADDR = 12'h0d4;
  localparam logic [11:0] STATE_ADDR = 12'h0d8;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int TRAP_BIT = 7;
  localparam int UFO_BIT = 6;
  localparam int VLOW_LSB = 5;
  localparam logic [2:0] REQ_EN_RESET = 3'h1;  // req0 on, req1/req2 off
  localparam logic [2:0] VLOW_RESET = 3'h0;
  localparam logic [7:0] VBASE_RESET = 8'h00;

  // ----------------------------------------------------------------
  // restart addresses, vector codes, timing
  // ----------------------------------------------------------------
  localparam logic [15:0] NMI_RESTART = 16'h0066;
  localparam logic [15:0] MODE1_RESTART = 16'h0038;
  localparam int NUM_SOURCES = 9;  // req1, req2, seven on-chip sources
  localparam logic [4:0] FIXED_CODE [NUM_SOURCES] = '{
    5'h00, 5'h02, 5'h04, 5'h06, 5'h08, 5'h0a, 5'h0c, 5'h0e, 5'h10};
  localparam logic [1:0] EXT_WAIT_STATES = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_NMI = 2'h0,
    KIND_MODE0 = 2'h1,
    KIND_MODE1 = 2'h2,
    KIND_VECTOR = 2'h3
  } resp_kind_t;

  typedef enum logic [2:0] {
    ACK_IDLE = 3'b000,
    ACK_T1 = 3'b001,
    ACK_T2 = 3'b011,
    ACK_WAIT = 3'b010,
    ACK_T3 = 3'b110,
    ACK_DONE = 3'b111
  } ack_state_t;

  // response handed to the core at the end of an acknowledge
  typedef struct packed {
    logic valid;
    resp_kind_t kind;
    logic push_pc;
    logic use_table;
    logic [7:0] instr;
    logic [15:0] target;
  } irq_resp_t;

  // acknowledge bus strobes
  typedef struct packed {
    logic fetch_strobe_n;
    logic io_enable_n;
    logic status_out;
    logic in_wait_state;
  } ack_bus_t;

endpackage

// ==== hdl/cpu_interrupt_response_unit.sv ====
// interrupt acceptance and response logic of an 8-bit processor.
// assumes the core gives one-cycle pulses for the sampling point and the
// end of the last machine cycle, and for the interrupt-related opcodes.
//
// The placing of the registers and the APB slave port were left to the implementer.
module cpu_interrupt_response_unit #(
  parameter int NUM_PERIPH = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // request inputs
  input wire logic nmi_n,
  input wire logic maskable_request0_n,
  input wire logic maskable_request1_n,
  input wire logic maskable_request2_n,
  input wire logic [NUM_PERIPH-1:0] periph_request,
  // core timing and instruction pulses
  input wire logic sample_point,
  input wire logic cycle_end,
  input wire logic enable_irq_instr,
  input wire logic disable_irq_instr,
  input wire logic set_irq_mode_instr,
  input wire logic [1:0] set_irq_mode_value,
  input wire logic nonmaskable_return_instr,
  input wire logic maskable_return_instr,
  input wire logic opcode_undefined,
  // acknowledge bus
  input wire logic [7:0] data_bus_in,
  output irq_resp_pkg::ack_bus_t ack_bus,
  output logic ack_busy,
  // results
  output irq_resp_pkg::irq_resp_t resp,
  output logic trap_request,
  output logic dma_enable_clear,
  output logic global_irq_enable,
  output logic saved_irq_enable
);
  import irq_resp_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic nmi_n_prev_r;
  logic nmi_latched_r;
  logic global_irq_enable_r;
  logic saved_irq_enable_r;
  logic [1:0] irq_mode_r;
  logic [2:0] req_enable_r;
  logic [2:0] vlow_r;
  logic [7:0] vbase_r;
  logic trap_flag_r;
  ack_state_t ack_state_r;
  ack_state_t ack_state_nxt;
  logic [1:0] wait_cnt_r;
  logic accepted_r;
  resp_kind_t sel_kind_r;
  logic [4:0] sel_code_r;
  logic sel_external_r;
  logic sel_req0_r;
  logic [7:0] captured_r;
  irq_resp_t resp_r;

  logic nmi_edge;
  logic req0_live;
  logic [NUM_SOURCES-1:0] vec_req;
  logic any_vec;
  logic [4:0] vec_code;
  logic take_nmi;
  logic take_any;
  logic resp_maskable;
  logic apb_write;
  logic apb_read;
  logic addr_hit;

  // ----------------------------------------------------------------
  // request detection and priority
  // ----------------------------------------------------------------

  // falling edge of the nmi pin
  assign nmi_edge = nmi_n_prev_r & ~nmi_n;
  assign req0_live = ~maskable_request0_n & global_irq_enable_r & req_enable_r[0];
  // vectored sources in priority order, request1 first
  assign vec_req[0] = ~maskable_request1_n & req_enable_r[1] & global_irq_enable_r;
  assign vec_req[1] = ~maskable_request2_n & req_enable_r[2] & global_irq_enable_r;
  assign vec_req[NUM_SOURCES-1:2] = periph_request & {NUM_PERIPH{global_irq_enable_r}};
  assign any_vec = |vec_req;
  assign take_nmi = sample_point & ~ack_busy & nmi_latched_r;
  assign take_any = sample_point & ~ack_busy & (nmi_latched_r | req0_live | any_vec);

  // lowest index wins, so only the top request is chosen
  always_comb begin
    vec_code = FIXED_CODE[0];
    for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
      if (vec_req[i]) begin
        vec_code = FIXED_CODE[i];
      end
    end
  end

  // previous nmi level for the edge detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_n_prev_r <= 1'b1;
    end else begin
      nmi_n_prev_r <= nmi_n;
    end
  end

  // nmi latch: a new edge wins over the clear from sampling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_latched_r <= 1'b0;
    end else if (nmi_edge) begin
      nmi_latched_r <= 1'b1;
    end else if (take_nmi) begin
      nmi_latched_r <= 1'b0;
    end
  end

  // selection captured at the sampling point
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accepted_r <= 1'b0;
      sel_kind_r <= KIND_NMI;
      sel_code_r <= 5'h00;
      sel_external_r <= 1'b0;
      sel_req0_r <= 1'b0;
    end else if (take_any) begin
      accepted_r <= 1'b1;
      sel_code_r <= vec_code;
      sel_external_r <= 1'b0;
      sel_req0_r <= req0_live & ~nmi_latched_r;
      if (nmi_latched_r) begin
        sel_kind_r <= KIND_NMI;
      end else if (req0_live) begin
        sel_external_r <= (irq_mode_r != 2'h1);
        unique case (irq_mode_r)
          2'h0: sel_kind_r <= KIND_MODE0;
          2'h1: sel_kind_r <= KIND_MODE1;
          default: sel_kind_r <= KIND_VECTOR;
        endcase
      end else begin
        sel_kind_r <= KIND_VECTOR;
      end
    end else if (ack_state_r == ACK_T1) begin
      accepted_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // acknowledge cycle sequencer
  // ----------------------------------------------------------------

  // next state: starts at the end of the sampled machine cycle
  always_comb begin
    ack_state_nxt = ack_state_r;
    unique case (ack_state_r)
      ACK_IDLE: begin
        if (accepted_r && cycle_end) begin
          ack_state_nxt = ACK_T1;
        end
      end
      ACK_T1: ack_state_nxt = ACK_T2;
      ACK_T2: ack_state_nxt = sel_external_r ? ACK_WAIT : ACK_T3;
      ACK_WAIT: begin
        if (wait_cnt_r == EXT_WAIT_STATES - 2'h1) begin
          ack_state_nxt = ACK_T3;
        end
      end
      ACK_T3: ack_state_nxt = ACK_DONE;
      ACK_DONE: ack_state_nxt = ACK_IDLE;
      default: ack_state_nxt = ACK_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_state_r <= ACK_IDLE;
    end else begin
      ack_state_r <= ack_state_nxt;
    end
  end

  // wait state counter for external fetches of request0 in modes 0 and 2
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt_r <= 2'h0;
    end else if (ack_state_r == ACK_WAIT) begin
      wait_cnt_r <= wait_cnt_r + 2'h1;
    end else begin
      wait_cnt_r <= 2'h0;
    end
  end

  // data bus captured as the third state ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      captured_r <= 8'h00;
    end else if (ack_state_r == ACK_T3 && sel_external_r) begin
      captured_r <= data_bus_in;
    end
  end

  assign ack_busy = accepted_r | (ack_state_r != ACK_IDLE);

  // strobes: low for every request0 acknowledge, any mode
  always_comb begin
    ack_bus.fetch_strobe_n = 1'b1;
    ack_bus.io_enable_n = 1'b1;
    ack_bus.status_out = 1'b1;
    ack_bus.in_wait_state = (ack_state_r == ACK_WAIT);
    if (ack_state_r != ACK_IDLE && ack_state_r != ACK_DONE) begin
      ack_bus.status_out = 1'b0;
      ack_bus.fetch_strobe_n = ~sel_req0_r;
      ack_bus.io_enable_n = ~sel_req0_r;
    end
  end

  // ----------------------------------------------------------------
  // response to the core
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_r <= '0;
    end else if (ack_state_r == ACK_DONE) begin
      resp_r.valid <= 1'b1;
      resp_r.kind <= sel_kind_r;
      resp_r.instr <= captured_r;
      unique case (sel_kind_r)
        KIND_NMI: begin
          resp_r.push_pc <= 1'b1;
          resp_r.use_table <= 1'b0;
          resp_r.target <= NMI_RESTART;
        end
        KIND_MODE0: begin
          resp_r.push_pc <= 1'b0;
          resp_r.use_table <= 1'b0;
          resp_r.target <= 16'h0000;
        end
        KIND_MODE1: begin
          resp_r.push_pc <= 1'b1;
          resp_r.use_table <= 1'b0;
          resp_r.target <= MODE1_RESTART;
        end
        KIND_VECTOR: begin
          resp_r.push_pc <= 1'b1;
          resp_r.use_table <= 1'b1;
          if (sel_external_r) begin
            resp_r.target <= {vbase_r, captured_r};
          end else begin
            resp_r.target <= {vbase_r, vlow_r, sel_code_r};
          end
        end
      endcase
    end else begin
      resp_r.valid <= 1'b0;
    end
  end

  assign resp = resp_r;
  assign resp_maskable = resp_r.valid & (resp_r.kind != KIND_NMI);
  // the core's decoder judges the captured mode 0 opcode
  assign trap_request = resp_r.valid & (resp_r.kind == KIND_MODE0) & opcode_undefined;
  assign dma_enable_clear = resp_r.valid & (resp_r.kind == KIND_NMI);

  // ----------------------------------------------------------------
  // enable flags and mode
  // ----------------------------------------------------------------

  // acknowledge effects take precedence over opcodes in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_irq_enable_r <= 1'b0;
      saved_irq_enable_r <= 1'b0;
    end else if (dma_enable_clear) begin
      saved_irq_enable_r <= global_irq_enable_r;
      global_irq_enable_r <= 1'b0;
    end else if (resp_maskable) begin
      global_irq_enable_r <= 1'b0;
      saved_irq_enable_r <= 1'b0;
    end else if (nonmaskable_return_instr) begin
      global_irq_enable_r <= saved_irq_enable_r;
    end else if (enable_irq_instr) begin
      global_irq_enable_r <= 1'b1;
      saved_irq_enable_r <= 1'b1;
    end else if (disable_irq_instr) begin
      global_irq_enable_r <= 1'b0;
      saved_irq_enable_r <= 1'b0;
    end
  end

  // response mode of request0; value 3 is not a mode and is ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mode_r <= 2'h0;
    end else if (set_irq_mode_instr && set_irq_mode_value != 2'h3) begin
      irq_mode_r <= set_irq_mode_value;
    end
  end

  assign global_irq_enable = global_irq_enable_r;
  assign saved_irq_enable = saved_irq_enable_r;

  // ----------------------------------------------------------------
  // apb register file
  // ----------------------------------------------------------------
  assign apb_write = psel & penable & pwrite;
  assign apb_read = psel & ~pwrite;
  assign addr_hit = (paddr == VLOW_ADDR) | (paddr == TRAP_CTRL_ADDR) |
                    (paddr == VBASE_ADDR) | (paddr == STATE_ADDR);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;

  // vector low bits, vector base and individual enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vlow_r <= VLOW_RESET;
      vbase_r <= VBASE_RESET;
      req_enable_r <= REQ_EN_RESET;
    end else if (apb_write) begin
      if (paddr == VLOW_ADDR) begin
        vlow_r <= pwdata[7:VLOW_LSB];
      end
      if (paddr == VBASE_ADDR) begin
        vbase_r <= pwdata[7:0];
      end
      if (paddr == TRAP_CTRL_ADDR) begin
        req_enable_r <= pwdata[2:0];
      end
    end
  end

  // trap flag: set by hardware, software may only clear it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trap_flag_r <= 1'b0;
    end else if (trap_request) begin
      trap_flag_r <= 1'b1;
    end else if (apb_write && paddr == TRAP_CTRL_ADDR && !pwdata[TRAP_BIT]) begin
      trap_flag_r <= 1'b0;
    end
  end

  // read data, registered during the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_read && !penable) begin
      unique case (paddr)
        VLOW_ADDR: prdata <= {24'h000000, vlow_r, 5'h00};
        TRAP_CTRL_ADDR: prdata <= {24'h000000, trap_flag_r, 1'b0, 3'h0, req_enable_r};
        VBASE_ADDR: prdata <= {24'h000000, vbase_r};
        STATE_ADDR: prdata <= {24'h000000, 1'b0, ack_busy, nmi_latched_r,
                               saved_irq_enable_r, global_irq_enable_r, 1'b0, irq_mode_r};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ==== tb/irq_resp_assertions.sv ====
// checker for the interrupt response unit, bound to its top-level ports.
// assumes one pclk domain and irq_resp_pkg compiled beforehand.
module irq_resp_checker
  import irq_resp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable_irq_instr,
  input wire logic nonmaskable_return_instr,
  input wire logic opcode_undefined,
  input wire irq_resp_pkg::ack_bus_t ack_bus,
  input wire irq_resp_pkg::irq_resp_t resp,
  input wire logic trap_request,
  input wire logic dma_enable_clear,
  input wire logic global_irq_enable,
  input wire logic saved_irq_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------
  // response, flag and strobe properties
  // ------------------------------------------------
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  nmi_resp_a: assert property (
    resp.valid && resp.kind == KIND_NMI |->
      resp.push_pc && resp.target == 16'h0066 && dma_enable_clear)
    else $error("nmi response wrong");
  nmi_flags_a: assert property (
    resp.valid && resp.kind == KIND_NMI |=>
      !global_irq_enable && saved_irq_enable == $past(global_irq_enable))
    else $error("nmi flag save wrong");
  mode1_resp_a: assert property (
    resp.valid && resp.kind == KIND_MODE1 |-> resp.push_pc && resp.target == 16'h0038
      ##1 !global_irq_enable && !saved_irq_enable)
    else $error("mode 1 response wrong");
  vector_resp_a: assert property (
    resp.valid && resp.kind == KIND_VECTOR |-> resp.push_pc && resp.use_table
      ##1 !global_irq_enable && !saved_irq_enable)
    else $error("vectored response wrong");
  mode0_push_a: assert property (
    resp.valid && resp.kind == KIND_MODE0 |-> !resp.push_pc)
    else $error("mode 0 pushed pc");
  trap_raise_a: assert property (
    trap_request == (resp.valid && resp.kind == KIND_MODE0 && opcode_undefined))
    else $error("trap request wrong");
  return_flag_a: assert property (
    nonmaskable_return_instr && !resp.valid |=> global_irq_enable == $past(saved_irq_enable))
    else $error("return did not restore enable");
  enable_flag_a: assert property (
    enable_irq_instr && !resp.valid && !nonmaskable_return_instr |=> global_irq_enable)
    else $error("enable instruction ignored");
  wait_pair_a: assert property (
    $rose(ack_bus.in_wait_state) |->
      (ack_bus.in_wait_state && !ack_bus.fetch_strobe_n && !ack_bus.io_enable_n) [*2]
      ##1 !ack_bus.in_wait_state)
    else $error("external fetch waits wrong");
  strobe_pair_a: assert property (
    !ack_bus.status_out |-> ack_bus.fetch_strobe_n == ack_bus.io_enable_n)
    else $error("acknowledge strobes split");
endmodule

bind cpu_interrupt_response_unit irq_resp_checker u_chk (
  .pclk(pclk), .presetn(presetn), .enable_irq_instr(enable_irq_instr),
  .nonmaskable_return_instr(nonmaskable_return_instr), .opcode_undefined(opcode_undefined),
  .ack_bus(ack_bus), .resp(resp), .trap_request(trap_request),
  .dma_enable_clear(dma_enable_clear), .global_irq_enable(global_irq_enable),
  .saved_irq_enable(saved_irq_enable));

// ==== tb/irq_source_model.sv ====
// model of the interrupting devices and on-chip peripherals.
// assumes the bench sets the wanted request levels and the reply byte.
module irq_source_model
  import irq_resp_pkg::*;
(
  input wire logic pclk,
  input wire logic [2:0] want_ext,
  input wire logic [6:0] want_periph,
  input wire logic nmi_level,
  input wire logic [7:0] reply,
  input wire irq_resp_pkg::ack_bus_t ack_bus,
  output logic nmi_n,
  output logic [2:0] req_n,
  output logic [6:0] periph_request,
  output logic [7:0] data_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last_r = 8'h5a;
  // requests held low while wanted, so they stand at the sampling point
  assign req_n = ~want_ext;
  assign periph_request = want_periph;
  assign nmi_n = ~nmi_level;
  // byte offered only while both strobes are low, else a changing pattern
  assign data_bus = (!ack_bus.fetch_strobe_n && !ack_bus.io_enable_n) ? reply : ~last_r;
  always_ff @(posedge pclk) begin
    last_r <= data_bus;
  end
endmodule

// ==== tb/cpu_interrupt_response_unit_bench.sv ====
// self-checking bench for the interrupt response unit.
// assumes the package, the bound checker and the source model.
module cpu_interrupt_response_unit_bench import irq_resp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, ack_busy, trap_request, dma_enable_clear, gie, sie, nmi_n;
  logic sample_point = 1'h0, cycle_end = 1'h0, undef = 1'h0, nmi_level = 1'h0;
  logic [4:0] ins = 5'h00;  // enable, disable, set mode, nmi return, return
  logic [1:0] mode_v = 2'h0;
  logic [2:0] want_ext = 3'h0, req_n;
  logic [6:0] want_periph = 7'h00, periph_request;
  logic [7:0] reply = 8'h00, data_bus, vbase, vlow, b;
  ack_bus_t ack_bus;
  irq_resp_t resp;
  logic [18:0] expq[$];
  int n_fail = 0, checks = 0;

  initial forever #2 pclk = ~pclk;

  cpu_interrupt_response_unit #(.NUM_PERIPH(7)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nmi_n(nmi_n), .maskable_request0_n(req_n[0]), .maskable_request1_n(req_n[1]),
    .maskable_request2_n(req_n[2]), .periph_request(periph_request),
    .sample_point(sample_point), .cycle_end(cycle_end), .enable_irq_instr(ins[0]),
    .disable_irq_instr(ins[1]), .set_irq_mode_instr(ins[2]), .set_irq_mode_value(mode_v),
    .nonmaskable_return_instr(ins[3]), .maskable_return_instr(ins[4]),
    .opcode_undefined(undef), .data_bus_in(data_bus), .ack_bus(ack_bus),
    .ack_busy(ack_busy), .resp(resp), .trap_request(trap_request),
    .dma_enable_clear(dma_enable_clear), .global_irq_enable(gie), .saved_irq_enable(sie));

  irq_source_model u_src (
    .pclk(pclk), .want_ext(want_ext), .want_periph(want_periph), .nmi_level(nmi_level),
    .reply(reply), .ack_bus(ack_bus), .nmi_n(nmi_n), .req_n(req_n),
    .periph_request(periph_request), .data_bus(data_bus));

  // ------------------------------------------------
  // reporting and comparison
  // ------------------------------------------------
  task automatic fail(string m);
    $display("[FAIL] %0t %s", $time, m);
    n_fail++;
  endtask
  task automatic cmp_reg(logic [31:0] got, logic [31:0] exp, string m);
    checks++;
    if (got !== exp) fail(m);
  endtask
  task automatic cmp_resp(logic [18:0] got, logic [18:0] exp);
    checks++;
    if (got !== exp) fail("response mismatch");
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ------------------------------------------------
  // apb master, core pulses and expectations
  // ------------------------------------------------
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] wd, output logic [32:0] re);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    re = {pslverr, prdata};
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 50) begin
      fail("apb timeout");
      conclude();
    end
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    logic [32:0] re;
    apb(1'h1, a, d, re);
  endtask
  task automatic rchk(logic [11:0] a, logic [32:0] exp, string m);
    logic [32:0] re;
    apb(1'h0, a, 32'h0, re);
    cmp_reg(re[31:0], exp[31:0], m);
    cmp_reg({31'h0, re[32]}, {31'h0, exp[32]}, m);
  endtask
  task automatic op(logic [4:0] v);
    @(posedge pclk);
    ins <= v;
    @(posedge pclk);
    ins <= 5'h00;
    @(posedge pclk);  // flags settle before the caller looks
  endtask
  task automatic expect_resp(resp_kind_t k, logic push, logic [15:0] v);
    expq.push_back({k, push, v});
  endtask
  // one last machine cycle: sampling point, end, then wait out any acknowledge
  task automatic mcycle();
    int n;
    @(posedge pclk);
    sample_point <= 1'h1;
    @(posedge pclk);
    sample_point <= 1'h0;
    cycle_end <= 1'h1;
    @(posedge pclk);
    cycle_end <= 1'h0;
    n = 0;
    while ((expq.size() != 0 || ack_busy !== 1'h0) && n < 40) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 40) begin
      fail("no response");
      conclude();
    end
    repeat (3) @(posedge pclk);
  endtask

  // takes the oldest expectation whenever a response appears
  always @(posedge pclk) begin
    if (presetn && resp.valid === 1'h1) begin
      if (expq.size() == 0) fail("unexpected response");
      else cmp_resp({resp.kind, resp.push_pc,
          resp.kind == KIND_MODE0 ? {8'h00, resp.instr} : resp.target}, expq.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge pclk);
    fail("run timeout");
    conclude();
  end

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    int i;
    b = 8'($urandom(32'hda126d23));
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    rchk(VLOW_ADDR, 33'h0, "vlow reset");
    rchk(TRAP_CTRL_ADDR, 33'h1, "ctrl reset");
    rchk(VBASE_ADDR, 33'h0, "vbase reset");
    rchk(STATE_ADDR, 33'h0, "state reset");
    rchk(12'h0fc, 33'h1_0000_0000, "unmapped");
    $display("test registers done");
    want_ext <= 3'h1;
    mcycle();
    op(5'h01);
    op(5'h02);
    cmp_reg({31'h0, gie}, 32'h0, "disable");
    op(5'h01);
    cmp_reg({31'h0, gie}, 32'h1, "enable");
    wr(TRAP_CTRL_ADDR, 32'h0);
    mcycle();
    wr(TRAP_CTRL_ADDR, 32'h1);
    nmi_level <= 1'h1;
    @(posedge pclk);
    nmi_level <= 1'h0;
    repeat (4) @(posedge pclk);
    expect_resp(KIND_NMI, 1'h1, 16'h0066);
    mcycle();
    cmp_reg({30'h0, gie, sie}, 32'h1, "nmi flags");
    mcycle();
    op(5'h08);
    cmp_reg({31'h0, gie}, 32'h1, "nmi return");
    want_ext <= 3'h0;
    $display("test nmi done");
    for (i = 0; i < 3; i++) begin
      mode_v <= i[1:0];
      op(5'h04);
      op(5'h01);
      b = 8'($urandom());
      vbase = 8'($urandom());
      wr(VBASE_ADDR, {24'h0, vbase});
      reply <= b;
      undef <= (i == 0);
      if (i == 0) expect_resp(KIND_MODE0, 1'h0, {8'h00, b});
      else if (i == 1) expect_resp(KIND_MODE1, 1'h1, 16'h0038);
      else expect_resp(KIND_VECTOR, 1'h1, {vbase, b});
      want_ext <= 3'h1;
      mcycle();
      want_ext <= 3'h0;
      undef <= 1'h0;
      cmp_reg({30'h0, gie, sie}, 32'h0, "flags after ack");
    end
    rchk(TRAP_CTRL_ADDR, 33'h81, "trap set");
    wr(TRAP_CTRL_ADDR, 32'h1);
    rchk(TRAP_CTRL_ADDR, 33'h1, "trap cleared");
    $display("test modes done");
    vlow = 8'($urandom());
    wr(VLOW_ADDR, {24'h0, vlow});
    wr(TRAP_CTRL_ADDR, 32'h4);
    op(5'h01);
    expect_resp(KIND_VECTOR, 1'h1, {vbase, vlow[7:5], 5'h02});
    want_ext <= 3'h6;
    mcycle();
    wr(TRAP_CTRL_ADDR, 32'h6);
    for (i = 0; i < 9; i++) begin
      op(5'h01);
      expect_resp(KIND_VECTOR, 1'h1, {vbase, vlow[7:5], 5'(2 * i)});
      want_ext <= {i <= 1, i == 0, 1'h0};
      want_periph <= 7'h7f << ((i > 2) ? i - 2 : 0);
      mcycle();
    end
    want_ext <= 3'h0;
    want_periph <= 7'h40;
    mcycle();
    want_periph <= 7'h00;
    $display("test vectored done");
    conclude();
  end
endmodule
